// ===== rtl/hcl_consts.svh
`ifndef HCL_CONSTS_SVH
`define HCL_CONSTS_SVH

`define HCL_CLK_NS        10
`define HCL_LINK_NS       48
`define HCL_POR_HOLD_NS   2700
`define HCL_POR_HOLD_CYC  ((`HCL_POR_HOLD_NS + `HCL_CLK_NS - 1) / `HCL_CLK_NS)
`define HCL_STRAP_MAX_NS  20000
`define HCL_STRAP_MAX_CYC (`HCL_STRAP_MAX_NS / `HCL_CLK_NS)
`define HCL_MODE_OUT_MS   50
`define HCL_MODE_OUT_CYC  ((`HCL_MODE_OUT_MS * 1000000 + `HCL_CLK_NS - 1) / `HCL_CLK_NS)
`define HCL_QTR_NS        2500
`define HCL_QTR_CYC       ((`HCL_QTR_NS + `HCL_LINK_NS - 1) / `HCL_LINK_NS)
`define HCL_LOAD_LEN      128

`define HCL_A_VID_LO      7'h00
`define HCL_A_VID_HI      7'h01
`define HCL_A_PID_LO      7'h02
`define HCL_A_PID_HI      7'h03
`define HCL_A_CHK         7'h04
`define HCL_A_RMV         7'h06
`define HCL_A_PORTS       7'h07
`define HCL_A_PWR         7'h08
`define HCL_A_VSTR        7'h10
`define HCL_A_PSTR        7'h40
`define HCL_A_SSTR        7'h70
`define HCL_N_CHK_BYTES   8'h04

`define HCL_CHK_ADD       8'h01
`define HCL_DEF_PWR       8'h32
`define HCL_MAX_PWR       8'hfa
`define HCL_DEF_PORTS     3'h4
`define HCL_MIN_PORTS     8'h01
`define HCL_MAX_PORTS     8'h04

`define HCL_I2C_WR        10'h280
`define HCL_I2C_RD        10'h284
`define HCL_I2C_ADR0      10'h000
`define HCL_SPI_READ      10'h300

`endif

// ===== rtl/hcl_pkg.sv
`default_nettype none
package hcl_pkg;
    typedef enum logic [1:0] {
        C_HOLD  = 2'b00,
        C_STRAP = 2'b01,
        C_LOAD  = 2'b10,
        C_DONE  = 2'b11
    } hcl_cst_t;
    typedef enum logic [2:0] {
        L_IDLE  = 3'b000,
        L_START = 3'b001,
        L_WBYTE = 3'b010,
        L_RBYTE = 3'b011,
        L_STOP  = 3'b100,
        L_DONE  = 3'b101
    } hcl_lst_t;
    typedef enum logic [1:0] {
        REF_12M = 2'b00,
        REF_27M = 2'b01,
        REF_48M = 2'b10
    } hcl_ref_t;
endpackage
`default_nettype wire

// ===== rtl/hcl_loader.sv
`timescale 1ns/100ps
`default_nettype none
`include "hcl_consts.svh"

// Notes on behaviour
// - after reset read memory, check it, adopt stored values only if check passes
// - check byte at 04h equals sum of four id bytes plus one
// - vendor id low byte from 00h, high byte from 01h when valid
// - product id low byte from 02h, high byte from 03h when valid
// - byte 06h bits 4:1 mark ports fixed; other bits zero
// - byte 07h gives port count, one to four, default from the port count straps
// - byte 08h is max power in 2 mA units, up to FAh, default 32h
// - vendor string length at 10h, characters 11h to 3Fh
// - product string length at 40h, characters 41h to 6Fh
// - serial length at 70h, characters from 71h upward
// - without valid memory use built-in default values
// - only one memory link, two-wire or three-wire, used at a time
// - three-wire memory is only read, never written
// - port-1 amber output disabled when three-wire memory present
// - internal reset released about 2.7 us after power good
// - mode pin sampled within 20 us: low individual, high gang
// - after 50 to 60 ms mode pin becomes suspend flag output
// - power enables active high when polarity strap 1, else active low
// - port count straps hi,lo: 11 one, 10 two, 01 three, 00 four
// - nonremovable_port_strap strap high marks that port non-removable
// - clock straps: 01 48 MHz, 10 27 MHz, 11 12 MHz
// - gang mode watches only port-1 overcurrent input
module hcl_loader
    import hcl_pkg::*;
#(
    parameter int          MODE_OUT_CYC = `HCL_MODE_OUT_CYC,
    parameter int          QTR_CYC      = `HCL_QTR_CYC,
    parameter logic [15:0] DEF_VID      = 16'h5a5a, // arbitrary value
    parameter logic [15:0] DEF_PID      = 16'h0c3c  // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        link_clk,
    input  wire logic        spi_mode_strap,
    input  wire logic        mode_pin_i,
    output logic             mode_pin_o,
    output logic             mode_pin_oe_n,
    input  wire logic        global_suspend,
    input  wire logic        power_switch_polarity_strap,
    input  wire logic        port_count_strap_hi,
    input  wire logic        port_count_strap_lo,
    input  wire logic [3:0]  nonremovable_port_strap,
    input  wire logic        osc_high_freq_select,
    input  wire logic        osc_mid_freq_select,
    input  wire logic [3:0]  overcurrent_in_n,
    input  wire logic [3:0]  port_power_req,
    input  wire logic        port1_amber_req,
    output logic             scl_o,
    output logic             scl_oe_n,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    output logic             spi_cs,
    output logic             spi_sk,
    output logic             spi_di,
    input  wire logic        spi_do,
    input  wire logic [6:0]  desc_rd_addr,
    output logic [7:0]       desc_rd_data,
    output logic [15:0]      vendor_id,
    output logic [15:0]      product_id,
    output logic [3:0]       nonremovable_port_strap_mask,
    output logic [2:0]       port_count,
    output logic [7:0]       max_power,
    output logic [7:0]       vendor_str_len,
    output logic [7:0]       product_str_len,
    output logic [7:0]       serial_str_len,
    output logic             gang_mode,
    output var hcl_ref_t     ref_clk_sel,
    output logic [3:0]       port_power_en,
    output logic [3:0]       overcurrent,
    output logic             port1_amber_indicator,
    output logic             cfg_valid,
    output logic             hub_attach_ok
);
    localparam int HOLD_CYC  = `HCL_POR_HOLD_CYC;
    localparam int STRAP_LIM = `HCL_STRAP_MAX_CYC;

    // ---------------- core domain ----------------
    hcl_cst_t    state, next_state;
    logic [8:0]  hold_cnt;
    logic [10:0] sp1, sp2;
    logic [3:0]  oc1, oc2;
    logic        strap_done, st_spi, st_pol;
    logic        start_tog;
    logic        cb1, cb2, cb3, cd1, ld_s, cn1, nack_s;
    logic [7:0]  mem [0:`HCL_LOAD_LEN-1];
    logic [7:0]  wr_idx, sum;
    logic [22:0] mode_cnt;
    logic        mode_out;
    logic [7:0]  link_byte;
    logic        byte_tog, ld_done, ld_nack;

    wire [10:0] strap_raw = {spi_mode_strap, mode_pin_i, power_switch_polarity_strap,
                             port_count_strap_hi, port_count_strap_lo,
                             nonremovable_port_strap, osc_high_freq_select,
                             osc_mid_freq_select};
    wire        hold_end = hold_cnt == 9'(HOLD_CYC - 1);
    wire        new_byte = cb2 ^ cb3;
    wire        load_end = state == C_LOAD && ld_s;
    wire [2:0]  strap_cnt = 3'h4 - {1'b0, sp2[7:6]};
    wire [3:0]  req_eff = port_power_req & {4{strap_done}};
    wire [7:0]  m_ports = mem[`HCL_A_PORTS];
    wire [7:0]  m_pwr = mem[`HCL_A_PWR];
    wire        chk_ok = mem[`HCL_A_CHK] == 8'(sum + `HCL_CHK_ADD);
    wire        cfg_ok = !nack_s && wr_idx == 8'(`HCL_LOAD_LEN) && chk_ok;
    wire        ports_ok = m_ports >= `HCL_MIN_PORTS && m_ports <= `HCL_MAX_PORTS;
    wire        pwr_ok = m_pwr <= `HCL_MAX_PWR;
    wire        mode_end = mode_cnt == 23'(MODE_OUT_CYC - 1);
    wire hcl_ref_t strap_ref = (sp2[1:0] == 2'b01) ? REF_48M :
                               (sp2[1:0] == 2'b10) ? REF_27M : REF_12M;

    always_comb begin
        next_state = state;
        case (state)
            C_HOLD:  if (hold_end) next_state = C_STRAP;
            C_STRAP: next_state = C_LOAD;
            C_LOAD:  if (ld_s) next_state = C_DONE;
            C_DONE:  next_state = C_DONE;
            default: next_state = C_HOLD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= C_HOLD;
            hold_cnt <= 9'h000;
            start_tog <= 1'b0;
        end else begin
            state <= next_state;
            if (state == C_HOLD) hold_cnt <= hold_cnt + 9'h001;
            start_tog <= start_tog ^ (state == C_STRAP);
        end
    end

    // pin and cross-domain synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            sp1 <= 11'h000;
            sp2 <= 11'h000;
            oc1 <= 4'hf;
            oc2 <= 4'hf;
            {cb1, cb2, cb3, cd1, ld_s, cn1, nack_s} <= 7'h00;
        end else begin
            sp1 <= strap_raw;
            sp2 <= sp1;
            oc1 <= overcurrent_in_n;
            oc2 <= oc1;
            {cb1, cb2, cb3} <= {byte_tog, cb1, cb2};
            {cd1, ld_s} <= {ld_done, cd1};
            {cn1, nack_s} <= {ld_nack, cn1};
        end
    end

    // strap capture, one cycle after the internal reset releases
    always_ff @(posedge clk) begin
        if (reset) begin
            strap_done <= 1'b0;
            st_spi <= 1'b0;
            st_pol <= 1'b0;
            gang_mode <= 1'b0;
            ref_clk_sel <= REF_12M;
        end else if (state == C_STRAP) begin
            strap_done <= 1'b1;
            st_spi <= sp2[10];
            gang_mode <= sp2[9];
            st_pol <= sp2[8];
            ref_clk_sel <= strap_ref;
        end
    end

    // bytes arrive in address order from 00h
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_idx <= 8'h00;
            sum <= 8'h00;
        end else if (new_byte && wr_idx < 8'(`HCL_LOAD_LEN)) begin
            wr_idx <= wr_idx + 8'h01;
            if (wr_idx < `HCL_N_CHK_BYTES) sum <= sum + link_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (new_byte && wr_idx < 8'(`HCL_LOAD_LEN)) mem[wr_idx[6:0]] <= link_byte;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_valid <= 1'b0;
            vendor_id <= DEF_VID;
            product_id <= DEF_PID;
            nonremovable_port_strap_mask <= 4'h0;
            port_count <= `HCL_DEF_PORTS;
            max_power <= `HCL_DEF_PWR;
            hub_attach_ok <= 1'b0;
        end else begin
            hub_attach_ok <= state == C_DONE;
            if (state == C_STRAP) begin
                port_count <= strap_cnt;
                nonremovable_port_strap_mask <= sp2[5:2];
            end
            if (load_end) begin
                cfg_valid <= cfg_ok;
                if (cfg_ok) begin
                    vendor_id <= {mem[`HCL_A_VID_HI], mem[`HCL_A_VID_LO]};
                    product_id <= {mem[`HCL_A_PID_HI], mem[`HCL_A_PID_LO]};
                    nonremovable_port_strap_mask <= nonremovable_port_strap_mask | mem[`HCL_A_RMV][4:1];
                    if (ports_ok) port_count <= m_ports[2:0];
                    if (pwr_ok) max_power <= m_pwr;
                end
            end
        end
    end

    // strings read as zero length unless the memory image is valid
    always_ff @(posedge clk) begin
        if (reset) begin
            desc_rd_data <= 8'h00;
            vendor_str_len <= 8'h00;
            product_str_len <= 8'h00;
            serial_str_len <= 8'h00;
        end else begin
            desc_rd_data <= cfg_valid ? mem[desc_rd_addr] : 8'h00;
            vendor_str_len <= cfg_valid ? mem[`HCL_A_VSTR] : 8'h00;
            product_str_len <= cfg_valid ? mem[`HCL_A_PSTR] : 8'h00;
            serial_str_len <= cfg_valid ? mem[`HCL_A_SSTR] : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_cnt <= 23'h000000;
            mode_out <= 1'b0;
            mode_pin_oe_n <= 1'b1;
            mode_pin_o <= 1'b0;
            port_power_en <= 4'h0;
            overcurrent <= 4'h0;
            port1_amber_indicator <= 1'b0;
        end else begin
            if (!mode_out) mode_cnt <= mode_cnt + 23'h000001;
            if (mode_end) mode_out <= 1'b1;
            mode_pin_oe_n <= !mode_out;
            mode_pin_o <= mode_out && global_suspend;
            port_power_en <= st_pol ? req_eff : ~req_eff;
            overcurrent <= ~oc2 & (gang_mode ? 4'h1 : 4'hf);
            port1_amber_indicator <= port1_amber_req && !st_spi;
        end
    end

    // ---------------- link domain ----------------
    hcl_lst_t    lst, next_lst;
    logic        lr1, lrst, lt1, lt2, lt3, lsp1, l_spi, in1, in2;
    logic [7:0]  qcnt, lcnt, rx;
    logic [1:0]  phase, wsel;
    logic [3:0]  bcnt;
    logic [9:0]  tx;
    logic        sda_v;

    wire       go = lt2 ^ lt3;
    wire       busy = lst inside {L_START, L_WBYTE, L_RBYTE, L_STOP};
    wire       qtr_end = qcnt == 8'(QTR_CYC - 1);
    wire       bit_end = busy && qtr_end && phase == 2'h3;
    wire [3:0] nbits = (lst == L_WBYTE) ? (l_spi ? 4'ha : 4'h9) : (l_spi ? 4'h8 : 4'h9);
    wire       byte_end = bit_end && bcnt == nbits - 4'h1;
    wire       last_rd = lcnt == 8'(`HCL_LOAD_LEN - 1);
    wire       ack_bad = !l_spi && in2;
    wire       scl_hi = phase != 2'h0;
    wire       shifting = lst inside {L_WBYTE, L_RBYTE};

    always_ff @(posedge link_clk) begin
        lr1 <= reset;
        lrst <= lr1;
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            {lt1, lt2, lt3, lsp1, l_spi, in1, in2} <= 7'h00;
        end else begin
            {lt1, lt2, lt3} <= {start_tog, lt1, lt2};
            {lsp1, l_spi} <= {st_spi, lsp1};
            in1 <= l_spi ? spi_do : sda_i;
            in2 <= in1;
        end
    end

    always_comb begin
        next_lst = lst;
        case (lst)
            L_IDLE:  if (go) next_lst = L_START;
            L_START: if (bit_end) next_lst = L_WBYTE;
            L_WBYTE: if (byte_end) begin
                if (ack_bad) next_lst = L_STOP;
                else if (l_spi || wsel == 2'h2) next_lst = L_RBYTE;
                else if (wsel == 2'h1) next_lst = L_START;
            end
            L_RBYTE: if (byte_end && last_rd) next_lst = L_STOP;
            L_STOP:  if (bit_end) next_lst = L_DONE;
            L_DONE:  next_lst = L_DONE;
            default: next_lst = L_IDLE;
        endcase
    end

    always_comb begin
        case (lst)
            L_START: sda_v = phase < 2'h2;
            L_STOP:  sda_v = phase >= 2'h2;
            L_WBYTE: sda_v = bcnt >= 4'h8 || tx[9];
            L_RBYTE: sda_v = bcnt < 4'h8 || last_rd;
            default: sda_v = 1'b1;
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            lst <= L_IDLE;
            qcnt <= 8'h00;
            phase <= 2'h0;
            bcnt <= 4'h0;
            wsel <= 2'h0;
        end else begin
            lst <= next_lst;
            qcnt <= (!busy || qtr_end) ? 8'h00 : qcnt + 8'h01;
            if (!busy) phase <= 2'h0;
            else if (qtr_end) phase <= phase + 2'h1;
            if (next_lst != lst || byte_end) bcnt <= 4'h0;
            else if (bit_end) bcnt <= bcnt + 4'h1;
            if (lst == L_WBYTE && byte_end) wsel <= wsel + 2'h1;
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            tx <= 10'h000;
            rx <= 8'h00;
        end else begin
            if (lst == L_START && bit_end)
                tx <= l_spi ? `HCL_SPI_READ :
                      (wsel == 2'h0 ? `HCL_I2C_WR : `HCL_I2C_RD);
            else if (lst == L_WBYTE && byte_end) tx <= `HCL_I2C_ADR0;
            else if (lst == L_WBYTE && bit_end) tx <= {tx[8:0], 1'b0};
            if (lst == L_RBYTE && bit_end && bcnt < 4'h8) rx <= {rx[6:0], in2};
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            lcnt <= 8'h00;
            link_byte <= 8'h00;
            byte_tog <= 1'b0;
            ld_nack <= 1'b0;
            ld_done <= 1'b0;
        end else begin
            if (lst == L_RBYTE && byte_end) begin
                link_byte <= l_spi ? {rx[6:0], in2} : rx;
                byte_tog <= ~byte_tog;
                lcnt <= lcnt + 8'h01;
            end
            if (lst == L_WBYTE && byte_end && ack_bad) ld_nack <= 1'b1;
            if (lst == L_STOP && bit_end) ld_done <= 1'b1;
        end
    end

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            spi_cs <= 1'b0;
            spi_sk <= 1'b0;
            spi_di <= 1'b0;
        end else begin
            scl_oe_n <= !(!l_spi && busy && !scl_hi);
            // sda moves only after scl is already low, never on the falling edge itself, except for start and stop, which move it with scl high
            if (!(phase == 2'h0 && scl_oe_n)) sda_oe_n <= l_spi || sda_v;
            spi_cs <= l_spi && busy;
            spi_sk <= l_spi && shifting && scl_hi;
            spi_di <= l_spi && lst == L_WBYTE && tx[9];
        end
    end

    // ---------------- checks ----------------
    sequence load_end_s;
        state == C_LOAD ##1 state == C_DONE;
    endsequence

    attach_after_load_a: assert property (
        @(posedge clk) disable iff (reset) load_end_s |=> hub_attach_ok)
        else $error("attach not raised after load");
    check_gate_a: assert property (
        @(posedge clk) disable iff (reset) $rose(cfg_valid) |-> chk_ok && !nack_s)
        else $error("config accepted with bad check byte");
    vid_take_a: assert property (
        @(posedge clk) disable iff (reset)
        load_end_s ##0 cfg_valid |-> vendor_id == {mem[`HCL_A_VID_HI], mem[`HCL_A_VID_LO]})
        else $error("vendor id not taken from memory");
    pid_take_a: assert property (
        @(posedge clk) disable iff (reset)
        load_end_s ##0 cfg_valid |-> product_id == {mem[`HCL_A_PID_HI], mem[`HCL_A_PID_LO]})
        else $error("product id not taken from memory");
    default_id_a: assert property (
        @(posedge clk) disable iff (reset) load_end_s ##0 !cfg_valid
        |-> vendor_id == DEF_VID && product_id == DEF_PID && max_power == `HCL_DEF_PWR)
        else $error("defaults not kept on invalid memory");
    hold_len_a: assert property (
        @(posedge clk) disable iff (reset) $rose(strap_done)
        |-> hold_cnt == 9'(HOLD_CYC) && hold_cnt < 9'(STRAP_LIM))
        else $error("internal reset hold length wrong");
    port_strap_a: assert property (
        @(posedge clk) disable iff (reset)
        state == C_STRAP |=> port_count == 3'h4 - {1'b0, $past(sp2[7:6])})
        else $error("port count strap decode wrong");
    gang_oc_a: assert property (
        @(posedge clk) disable iff (reset) gang_mode |=> overcurrent[3:1] == 3'h0)
        else $error("overcurrent 2..4 seen in gang mode");
    power_pol_a: assert property (
        @(posedge clk) disable iff (reset) strap_done |=> port_power_en ==
        (st_pol ? $past(port_power_req) : ~$past(port_power_req)))
        else $error("power enable polarity wrong");
    amber_off_a: assert property (
        @(posedge clk) disable iff (reset) st_spi |=> !port1_amber_indicator)
        else $error("amber driven with three-wire memory");
    mode_out_a: assert property (
        @(posedge clk) disable iff (reset)
        $rose(mode_out) |-> $past(mode_cnt) == 23'(MODE_OUT_CYC - 1) ##1 !mode_pin_oe_n)
        else $error("mode pin output switch timing wrong");
    one_link_a: assert property (
        @(posedge link_clk) disable iff (lrst) !(spi_cs && !sda_oe_n))
        else $error("both memory links active");
    spi_read_a: assert property (
        @(posedge link_clk) disable iff (lrst)
        l_spi && lst == L_START && bit_end |=> tx == `HCL_SPI_READ)
        else $error("three-wire command is not a read");

endmodule // hcl_loader
`default_nettype wire

// ===== tb/hcl_eeprom_model.sv
`timescale 1ns/100ps
`default_nettype none
module hcl_eeprom_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_drv,
    input  wire logic nack,
    input  wire logic cs,
    input  wire logic sk,
    input  wire logic di,
    output logic      dout
);
    logic [7:0] mem [128];
    logic [7:0] sh = 8'h00;
    logic [7:0] waddr = 8'h00;
    logic [6:0] ptr = 7'h00;
    logic [9:0] cmd = 10'h000;
    logic       rd = 1'b0, first = 1'b0, sdo = 1'b0;
    int         bc = 0, sc = 0, k = 0, starts = 0, frames = 0;
    initial sda_drv = 1'b1;
    // start and stop conditions
    always @(negedge sda) if (scl) begin
        bc = 0; rd = 0; first = 1; starts++;
    end
    always @(posedge sda) if (scl) rd = 0;
    always @(posedge scl) begin
        if (bc < 8) sh = {sh[6:0], sda};
        bc++;
        if (bc == 9) begin
            bc = 0;
            if (rd) begin
                if (sda) rd = 0;
                else ptr++;
            end else if (first) begin
                rd = sh[0]; first = 0;
            end else begin
                ptr = sh[6:0]; waddr = sh;
            end
        end
    end
    // released bits float to the pull-up level
    always @(negedge scl) sda_drv = rd ? (bc == 8 || mem[ptr][7 - bc]) : !(bc == 8 && !nack);
    // three-wire: count from the start bit, then shift data out msb first
    always @(posedge sk) if (cs && (sc > 0 || di)) begin
        if (sc < 10) cmd = {cmd[8:0], di};
        sc++;
    end
    always @(negedge sk) if (sc >= 10 && sc < 1034) begin
        k = sc - 10; sdo = mem[k / 8][7 - k % 8];
    end
    always @(posedge cs) frames++;
    always @(negedge cs) sc = 0;
    assign dout = cs ? sdo : !sdo;
endmodule // hcl_eeprom_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "hcl_consts.svh"
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", n, e, v); end end
module testbench;
    import hcl_pkg::*;
    localparam int          QTR = 2, MODE = 2000;
    localparam logic [15:0] DVID = 16'h1357, DPID = 16'h2468; // arbitrary values
    localparam logic [6:0]  AD [5] = '{7'h11, 7'h3f, 7'h41, 7'h6f, 7'h71};
    logic       clk = 0, link_clk = 0, reset = 1, spi_sel = 0, strap_mode = 0, nack = 0;
    logic       gsusp = 0, pol = 0, pc_hi = 0, pc_lo = 0, s_hi = 0, s_mid = 0, amber_req = 0;
    logic [3:0] nrm = 0, oc_n = 4'hf, preq = 0;
    logic [6:0] rd_addr = 0;
    int         n_fail = 0, total_checks = 0, cyc = 0, seed = 32'h0176db5e;
    wire        scl_oe_n, sda_oe_n, m_sda, mode_o, mode_oe_n, cs, sk, di, sdo, gang, amber;
    wire        valid, attach;
    wire [15:0] vid, pid;
    wire [7:0]  rdata, mpwr, vlen, plen, slen;
    wire [3:0]  fmask, pen, oc;
    wire [2:0]  pcount;
    hcl_ref_t   ref_sel;
    wire        scl = scl_oe_n;
    wire        sda = sda_oe_n & m_sda;
    wire        mode_pin = mode_oe_n ? strap_mode : mode_o;
    always #5 clk = ~clk;
    initial #2.3 forever #24 link_clk = ~link_clk;
    hcl_loader #(.MODE_OUT_CYC(MODE), .QTR_CYC(QTR), .DEF_VID(DVID), .DEF_PID(DPID)) i_hcl_loader (
        .clk(clk), .reset(reset), .link_clk(link_clk), .spi_mode_strap(spi_sel),
        .mode_pin_i(mode_pin), .mode_pin_o(mode_o), .mode_pin_oe_n(mode_oe_n),
        .global_suspend(gsusp), .power_switch_polarity_strap(pol), .port_count_strap_hi(pc_hi),
        .port_count_strap_lo(pc_lo), .nonremovable_port_strap(nrm), .osc_high_freq_select(s_hi),
        .osc_mid_freq_select(s_mid), .overcurrent_in_n(oc_n), .port_power_req(preq),
        .port1_amber_req(amber_req), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(),
        .sda_oe_n(sda_oe_n), .spi_cs(cs), .spi_sk(sk), .spi_di(di), .spi_do(sdo),
        .desc_rd_addr(rd_addr), .desc_rd_data(rdata), .vendor_id(vid), .product_id(pid),
        .nonremovable_port_strap_mask(fmask), .port_count(pcount), .max_power(mpwr), .vendor_str_len(vlen),
        .product_str_len(plen), .serial_str_len(slen), .gang_mode(gang), .ref_clk_sel(ref_sel),
        .port_power_en(pen), .overcurrent(oc), .port1_amber_indicator(amber),
        .cfg_valid(valid), .hub_attach_ok(attach));
    hcl_eeprom_model i_hcl_eeprom_model (.scl(scl), .sda(sda), .sda_drv(m_sda), .nack(nack),
        .cs(cs), .sk(sk), .di(di), .dout(sdo));
    function automatic logic [2:0] strap_ports(logic h, logic l);
        return 3'h4 - {1'b0, h, l};
    endfunction
    function automatic hcl_ref_t ref_exp(logic h, logic m);
        return (h ^ m) ? (h ? REF_27M : REF_48M) : REF_12M;
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic run(int r, logic use_spi, logic bad, logic nk);
        logic [7:0]  m [128];
        logic [31:0] q;
        logic        ok;
        int          i;
        reset = 1; spi_sel = use_spi; nack = nk; ok = !bad && !nk;
        q = $random(seed);
        {strap_mode, pol, pc_hi, pc_lo, s_hi, s_mid, nrm} = q[9:0];
        if (r == 0) strap_mode = 1;
        for (i = 0; i < 128; i++) begin
            q = $random(seed); m[i] = q[7:0];
        end
        m[6] = m[6] & 8'h1e;
        m[7] = 8'h01 + {6'h00, m[7][1:0]};
        m[8] = 8'hfa;
        m[4] = m[0] + m[1] + m[2] + m[3] + 8'h01 + {7'h00, bad};
        i_hcl_eeprom_model.mem = m;
        i_hcl_eeprom_model.starts = 0;
        i_hcl_eeprom_model.frames = 0;
        repeat (16) @(negedge clk);
        reset = 0;
        repeat (260) @(negedge clk);
        `CHK("gang early", 1'b0, gang)
        `CHK("mode dir early", 1'b1, mode_oe_n)
        repeat (30) @(negedge clk);
        `CHK("gang", strap_mode, gang)
        `CHK("ref clock", ref_exp(s_hi, s_mid), ref_sel)
        `CHK("attach early", 1'b0, attach)
        for (i = 0; i < 60000 && attach !== 1'b1; i++) @(negedge clk);
        `CHK("attach", 1'b1, attach)
        repeat (MODE) @(negedge clk);
        `CHK("valid", ok, valid)
        `CHK("vid", ok ? {m[1], m[0]} : DVID, vid)
        `CHK("pid", ok ? {m[3], m[2]} : DPID, pid)
        `CHK("fixed", nrm | (ok ? m[6][4:1] : 4'h0), fmask)
        `CHK("ports", ok ? m[7][2:0] : strap_ports(pc_hi, pc_lo), pcount)
        `CHK("power", ok ? m[8] : 8'h32, mpwr)
        `CHK("vlen", ok ? m[8'h10] : 8'h00, vlen)
        `CHK("plen", ok ? m[8'h40] : 8'h00, plen)
        `CHK("slen", ok ? m[8'h70] : 8'h00, slen)
        foreach (AD[j]) begin
            rd_addr = AD[j];
            repeat (2) @(negedge clk);
            `CHK("string byte", ok ? m[AD[j]] : 8'h00, rdata)
        end
        if (use_spi) begin
            `CHK("spi command", `HCL_SPI_READ, i_hcl_eeprom_model.cmd)
            `CHK("two-wire idle", 0, i_hcl_eeprom_model.starts)
        end else begin
            `CHK("word address", 8'h00, i_hcl_eeprom_model.waddr)
            `CHK("three-wire idle", 0, i_hcl_eeprom_model.frames)
        end
        repeat (4) begin
            q = $random(seed);
            {preq, oc_n, amber_req} = q[8:0];
            gsusp = ~gsusp;
            repeat (4) @(negedge clk);
            `CHK("power enable", pol ? preq : ~preq, pen)
            `CHK("overcurrent", strap_mode ? {3'h0, ~oc_n[0]} : ~oc_n, oc)
            `CHK("amber", amber_req & !use_spi, amber)
            `CHK("suspend flag", gsusp, mode_o)
            `CHK("mode dir", 1'b0, mode_oe_n)
        end
        $display("run %0d done", r);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 110000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        run(0, 1'b0, 1'b0, 1'b0);
        run(1, 1'b1, 1'b1, 1'b0);
        run(2, 1'b0, 1'b0, 1'b1);
        test_done;
    end
endmodule // testbench
`default_nettype wire
